// ==== asr_top.sv ====
/*
 * Asynchronous serial receiver: 16x oversampled data recovery, majority
 * bit decisions, two-character receive buffer with overrun blocking,
 * framing check, 9-bit and address-detect modes, Avalon-MM register slave.
 * Assumes a separate baud generator supplies a one-cycle tick at sixteen
 * times the bit rate, and that the serial line is asynchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.svh"

module asr_top (
	input wire logic sys_clk_in, // system clock, 200 MHz
	input wire logic rst_b_in, // async reset, active low
	input wire logic serial_in_pin_in, // serial receive line
	input wire logic baud_tick_in, // 16x bit-rate tick
	input wire logic [3:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [31:0] avs_writedata_in, // write data
	input wire logic [3:0] avs_byteenable_in, // write byte lanes
	output logic [31:0] avs_readdata_out, // read data
	output logic avs_waitrequest_out, // stall, low on answer
	output logic rx_irq_out // receive interrupt request
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [`ASR_CTRL_W-1:0] ctrl;
	logic rx_enabled;
	logic sync_first;
	logic sync_line;
	logic line;
	logic line_prev;
	logic fall_edge;
	asr_pkg::asr_state_e state;
	logic [3:0] tick_cnt;
	logic [3:0] bit_cnt;
	logic [3:0] bits_wanted;
	logic samp_first;
	logic samp_second;
	logic voted;
	logic at_vote;
	logic [8:0] shift_reg;
	logic char_done;
	logic char_ferr;
	logic [7:0] char_low;
	logic char_bit8;
	logic char_keep;
	logic overrun;
	logic [1:0] fifo_count;
	logic wr_ptr;
	logic rd_ptr;
	logic next_rd_ptr;
	logic push;
	logic pop;
	asr_pkg::asr_char_t head;
	logic pending;
	logic bus_req;
	logic bus_take;
	logic [31:0] next_readdata;

	// ---------------------------------------------------------------
	// control decode
	// ---------------------------------------------------------------

	// receiver runs only with enable set, async mode, port enabled
	assign rx_enabled = ctrl[`ASR_CB_RX_CONT_EN] & ~ctrl[`ASR_CB_SYNC]
		& ctrl[`ASR_CB_PORT_EN];
	assign bits_wanted = ctrl[`ASR_CB_NINE] ? `ASR_BITS_NINE
		: `ASR_BITS_EIGHT;

	// ---------------------------------------------------------------
	// line synchroniser and edge detect
	// ---------------------------------------------------------------

	// two flops before anything looks at the line
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync_first <= 1'b1;
			sync_line <= 1'b1;
		end else begin
			sync_first <= serial_in_pin_in;
			sync_line <= sync_first;
		end
	end

	// disabled receiver sees an idle-high line
	assign line = rx_enabled ? sync_line : 1'b1;

	// previous line level for falling-edge hunt
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			line_prev <= 1'b1;
		end else begin
			line_prev <= line;
		end
	end

	assign fall_edge = line_prev & ~line;

	// ---------------------------------------------------------------
	// oversampling and majority vote
	// ---------------------------------------------------------------

	// samples ahead of the bit centre
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			samp_first <= 1'b1;
			samp_second <= 1'b1;
		end else if (baud_tick_in && (state != asr_pkg::ASR_IDLE)) begin
			if (tick_cnt == `ASR_TICK_FIRST) begin
				samp_first <= line;
			end
			if (tick_cnt == `ASR_TICK_SECOND) begin
				samp_second <= line;
			end
		end
	end

	// three consecutive oversamples around the centre
	asr_vote u_vote (
		.a_in(samp_first),
		.b_in(samp_second),
		.c_in(line),
		.vote_out(voted)
	);

	// decision point, on a tick only
	assign at_vote = baud_tick_in && (tick_cnt == `ASR_TICK_VOTE);

	// ---------------------------------------------------------------
	// bit-timing state machine
	// ---------------------------------------------------------------

	// tick counter wraps every sixteen ticks, one bit period
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tick_cnt <= '0;
		end else if (!rx_enabled || (state == asr_pkg::ASR_IDLE)) begin
			tick_cnt <= '0;
		end else if (baud_tick_in) begin
			tick_cnt <= tick_cnt + `ASR_TICK_ONE;
		end
	end

	// start hunt, start check, data bits, stop bit
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= asr_pkg::ASR_IDLE;
		end else if (!rx_enabled) begin
			state <= asr_pkg::ASR_IDLE;
		end else begin
			case (state)
				asr_pkg::ASR_IDLE: begin
					if (fall_edge) begin
						state <= asr_pkg::ASR_START;
					end
				end
				asr_pkg::ASR_START: begin
					if (at_vote) begin
						// high at mid start bit: drop silently
						state <= voted ? asr_pkg::ASR_IDLE
							: asr_pkg::ASR_DATA;
					end
				end
				asr_pkg::ASR_DATA: begin
					if (at_vote && (bit_cnt == bits_wanted - `ASR_TICK_ONE)) begin
						state <= asr_pkg::ASR_STOP;
					end
				end
				asr_pkg::ASR_STOP: begin
					if (at_vote) begin
						state <= asr_pkg::ASR_IDLE;
					end
				end
				default: begin
					state <= asr_pkg::ASR_IDLE;
				end
			endcase
		end
	end

	// data bit counter
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bit_cnt <= '0;
		end else if (state != asr_pkg::ASR_DATA) begin
			bit_cnt <= '0;
		end else if (at_vote) begin
			bit_cnt <= bit_cnt + `ASR_TICK_ONE;
		end
	end

	// shifter advances once per bit, lsb first
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shift_reg <= '0;
		end else if ((state == asr_pkg::ASR_DATA) && at_vote) begin
			shift_reg <= {voted, shift_reg[8:1]};
		end
	end

	// ---------------------------------------------------------------
	// character completion
	// ---------------------------------------------------------------

	// stop bit decided: character complete
	assign char_done = (state == asr_pkg::ASR_STOP) && at_vote && rx_enabled;
	assign char_ferr = ~voted;
	assign char_low = ctrl[`ASR_CB_NINE] ? shift_reg[7:0] : shift_reg[8:1];
	assign char_bit8 = ctrl[`ASR_CB_NINE] & shift_reg[8];

	// address mode, with nine-bit mode set, drops characters without the ninth bit
	assign char_keep = ~(ctrl[`ASR_CB_ADDR_DET] & ctrl[`ASR_CB_NINE])
		| char_bit8;

	// buffer write only while not overrun and not full
	assign push = char_done && char_keep && !overrun
		&& (fifo_count != `ASR_FIFO_FULL);

	// overrun flag, cleared only by dropping receive enable
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			overrun <= 1'b0;
		end else if (!ctrl[`ASR_CB_RX_CONT_EN]) begin
			overrun <= 1'b0;
		end else if (char_done && char_keep && (fifo_count == `ASR_FIFO_FULL)) begin
			overrun <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// receive buffer
	// ---------------------------------------------------------------

	// only a bus read of the data register removes a character
	assign pop = bus_take && avs_read_in && (avs_address_in == `ASR_OFF_DATA)
		&& (fifo_count != `ASR_FIFO_EMPTY);
	assign next_rd_ptr = pop ? ~rd_ptr : rd_ptr;

	// pointers and fill level
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			fifo_count <= `ASR_FIFO_EMPTY;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			rd_ptr <= next_rd_ptr;
			if (push && !pop) begin
				fifo_count <= fifo_count + 2'h1;
			end else if (pop && !push) begin
				fifo_count <= fifo_count - 2'h1;
			end
		end
	end

	// storage, head word registered
	asr_fifo_mem u_mem (
		.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.wr_en_in(push),
		.wr_addr_in(wr_ptr),
		.wr_data_in({char_ferr, char_bit8, char_low}),
		.rd_addr_in(next_rd_ptr),
		.rd_data_out(head)
	);

	// pending flag: enabled and unread data, no interrupt enable involved
	assign pending = rx_enabled && (fifo_count != `ASR_FIFO_EMPTY);

	// interrupt request needs all three enables
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_irq_out <= 1'b0;
		end else begin
			rx_irq_out <= pending & ctrl[`ASR_CB_RXIE] & ctrl[`ASR_CB_PERIPH_IE]
				& ctrl[`ASR_CB_GLOBAL_IE];
		end
	end

	// ---------------------------------------------------------------
	// avalon-mm slave
	// ---------------------------------------------------------------

	assign bus_req = avs_read_in | avs_write_in;
	// access completes at the edge where waitrequest is seen low
	assign bus_take = bus_req & ~avs_waitrequest_out;

	// one wait cycle, then one answer cycle
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			avs_waitrequest_out <= 1'b1;
		end else begin
			avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
		end
	end

	// control register write, low byte lane
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl <= `ASR_CTRL_RST;
		end else if (bus_take && avs_write_in && avs_byteenable_in[0]
				&& (avs_address_in == `ASR_OFF_CTRL)) begin
			ctrl <= avs_writedata_in[`ASR_CTRL_W-1:0];
		end
	end

	// read mux; buffer and shifter have no write path
	always_comb begin
		next_readdata = '0;
		if (avs_address_in == `ASR_OFF_CTRL) begin
			next_readdata[`ASR_CTRL_W-1:0] = ctrl;
		end else if (avs_address_in == `ASR_OFF_STATUS) begin
			// head flags only while a character is unread; empty slots are stale
			next_readdata[`ASR_SB_BIT8] = head[8] & (fifo_count != `ASR_FIFO_EMPTY);
			next_readdata[`ASR_SB_FERR] = head[9] & (fifo_count != `ASR_FIFO_EMPTY);
			next_readdata[`ASR_SB_OVERRUN] = overrun;
			next_readdata[`ASR_SB_PEND] = pending;
			next_readdata[`ASR_SB_BUSY] = (state != asr_pkg::ASR_IDLE);
		end else if (avs_address_in == `ASR_OFF_DATA) begin
			next_readdata[7:0] = head[7:0];
		end else begin
			next_readdata = '0;
		end
	end

	// read data captured as waitrequest drops
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			avs_readdata_out <= '0;
		end else if (avs_read_in && avs_waitrequest_out) begin
			avs_readdata_out <= next_readdata;
		end
	end

endmodule

`default_nettype wire

// ==== asr_map.svh ====
/*
 * Register offsets, field positions, reset values and tick counts of the
 * asynchronous serial receiver.
 * Assumes a byte-addressed register bus with one 32-bit word per register.
 */
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define ASR_OFF_CTRL 4'h0
`define ASR_OFF_STATUS 4'h4
`define ASR_OFF_DATA 4'h8

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define ASR_CTRL_W 8
`define ASR_CTRL_RST 8'h00
`define ASR_CB_RX_CONT_EN 0
`define ASR_CB_SYNC 1
`define ASR_CB_PORT_EN 2
`define ASR_CB_NINE 3
`define ASR_CB_ADDR_DET 4
`define ASR_CB_RXIE 5
`define ASR_CB_PERIPH_IE 6
`define ASR_CB_GLOBAL_IE 7

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define ASR_SB_BIT8 0
`define ASR_SB_FERR 1
`define ASR_SB_OVERRUN 2
`define ASR_SB_PEND 3
`define ASR_SB_BUSY 4

// ---------------------------------------------------------------
// bit timing in oversampling ticks, counted from the start edge
// ---------------------------------------------------------------
`define ASR_TICK_FIRST 4'h6
`define ASR_TICK_SECOND 4'h7
`define ASR_TICK_VOTE 4'h8
`define ASR_TICK_ONE 4'h1
`define ASR_BITS_EIGHT 4'h8
`define ASR_BITS_NINE 4'h9

// ---------------------------------------------------------------
// receive buffer
// ---------------------------------------------------------------
`define ASR_FIFO_FULL 2'h2
`define ASR_FIFO_EMPTY 2'h0

`endif

// ==== asr_pkg.sv ====
/*
 * Types shared by the asynchronous serial receiver files.
 * Assumes asr_map.svh supplies all numeric constants.
 */
`default_nettype none

package asr_pkg;

	// receiver bit-timing states
	typedef enum logic [1:0] {
		ASR_IDLE,
		ASR_START,
		ASR_DATA,
		ASR_STOP
	} asr_state_e;

	// one buffered character: framing error, ninth bit, low byte
	typedef logic [9:0] asr_char_t;

endpackage

`default_nettype wire

// ==== asr_vote.sv ====
/*
 * Majority of three line samples.
 * Assumes the three samples are already synchronous to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module asr_vote (
	input wire logic a_in, // first sample
	input wire logic b_in, // second sample
	input wire logic c_in, // third sample
	output logic vote_out // majority level
);

	// two of three agree
	assign vote_out = (a_in & b_in) | (a_in & c_in) | (b_in & c_in);

endmodule

`default_nettype wire

// ==== asr_fifo_mem.sv ====
/*
 * Two-word storage for received characters, registered read port.
 * Assumes the caller handles pointers and never writes a full buffer.
 */
`timescale 1ns/1ps
`default_nettype none

module asr_fifo_mem (
	input wire logic sys_clk_in, // system clock
	input wire logic rst_b_in, // async reset, active low
	input wire logic wr_en_in, // write strobe
	input wire logic wr_addr_in, // write slot
	input wire asr_pkg::asr_char_t wr_data_in, // character to store
	input wire logic rd_addr_in, // slot to present next cycle
	output asr_pkg::asr_char_t rd_data_out // registered read data
);

	asr_pkg::asr_char_t mem [0:1];

	// storage write
	always_ff @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	// registered read with write-through
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_data_out <= '0;
		end else if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
			rd_data_out <= wr_data_in;
		end else begin
			rd_data_out <= mem[rd_addr_in];
		end
	end

endmodule

`default_nettype wire

// ==== asr_tx_model.sv ====
/*
 * Remote asynchronous transmitter model that drives the receive line.
 * Assumes the same 16x tick that the receiver gets from its baud source.
 */
`timescale 1ns/1ps
`default_nettype none

module asr_tx_model (
	input wire logic clk_in, // system clock
	input wire logic tick_in, // 16x bit-rate tick
	output logic line_out // serial line, idle high
);
	// line idles high as a plain digital pin
	initial line_out = 1'b1;

	// wait a number of oversample ticks
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk_in);
			while (tick_in !== 1'b1) @(posedge clk_in);
		end
	endtask

	// one frame, lsb first, with a chosen stop level
	task automatic send(input logic [8:0] d, input int nb, input logic stop);
		line_out <= 1'b0;
		ticks(16);
		for (int i = 0; i < nb; i++) begin
			line_out <= d[i];
			ticks(16);
		end
		line_out <= stop;
		ticks(16);
		line_out <= 1'b1;
		ticks(8);
	endtask

	// short low pulse that ends before mid start bit
	task automatic glitch();
		line_out <= 1'b0;
		ticks(4);
		line_out <= 1'b1;
		ticks(32);
	endtask
endmodule
`default_nettype wire

// ==== asr_top_checker.sv ====
/*
 * Port-level assertions for the serial receiver.
 * Assumes it is bound to asr_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.svh"

module asr_top_checker (
	input wire logic sys_clk_in, // system clock
	input wire logic rst_b_in, // async reset, active low
	input wire logic [3:0] avs_address_in, // byte address
	input wire logic avs_read_in, // read request
	input wire logic avs_write_in, // write request
	input wire logic [31:0] avs_writedata_in, // write data
	input wire logic [3:0] avs_byteenable_in, // write lanes
	input wire logic [31:0] avs_readdata_out, // read data
	input wire logic avs_waitrequest_out, // stall
	input wire logic rx_irq_out // interrupt request
);
	logic [7:0] ctrl;
	logic rd_done;
	logic irq_en;
	logic rx_on;

	// shadow of the control register from completed writes
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl <= 8'h00;
		end else if (avs_write_in && !avs_waitrequest_out &&
				avs_address_in == `ASR_OFF_CTRL && avs_byteenable_in[0]) begin
			ctrl <= avs_writedata_in[7:0];
		end
	end

	// decoded enables and read completion
	assign rd_done = avs_read_in && !avs_waitrequest_out;
	assign irq_en = ctrl[`ASR_CB_RXIE] & ctrl[`ASR_CB_PERIPH_IE] & ctrl[`ASR_CB_GLOBAL_IE];
	assign rx_on = ctrl[`ASR_CB_RX_CONT_EN] & !ctrl[`ASR_CB_SYNC] & ctrl[`ASR_CB_PORT_EN];

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	property p_wait_answer;
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
	endproperty
	a_wait_answer: assert property (p_wait_answer) else $error("no answer after wait");
	property p_wait_one;
		!avs_waitrequest_out |=> avs_waitrequest_out;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
	property p_wait_cause;
		$fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in);
	endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
	property p_ctrl_back;
		rd_done && avs_address_in == `ASR_OFF_CTRL |-> avs_readdata_out == {24'h0, ctrl};
	endproperty
	a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");
	property p_unmapped;
		rd_done && !(avs_address_in inside {`ASR_OFF_CTRL, `ASR_OFF_STATUS, `ASR_OFF_DATA})
			|-> avs_readdata_out == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_data_upper;
		rd_done && avs_address_in == `ASR_OFF_DATA |-> avs_readdata_out[31:8] == 24'h0;
	endproperty
	a_data_upper: assert property (p_data_upper) else $error("data upper bits set");
	property p_irq_gate;
		(!irq_en)[*3] |-> !rx_irq_out;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq with enables off");
	property p_irq_dis;
		(!rx_on)[*3] |-> !rx_irq_out;
	endproperty
	a_irq_dis: assert property (p_irq_dis) else $error("irq while disabled");
	property p_idle_busy;
		(!rx_on)[*3] ##0 (rd_done && avs_address_in == `ASR_OFF_STATUS)
			|-> avs_readdata_out[`ASR_SB_BUSY] == 1'b0;
	endproperty
	a_idle_busy: assert property (p_idle_busy) else $error("busy while disabled");
endmodule

bind asr_top asr_top_checker u_chk (
	.sys_clk_in(sys_clk_in),
	.rst_b_in(rst_b_in),
	.avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in),
	.avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out),
	.rx_irq_out(rx_irq_out)
);
`default_nettype wire

// ==== tb_asr_top.sv ====
/*
 * Self-checking bench for the serial receiver.
 * Assumes asr_tx_model drives the line and the bench is the bus master.
 */
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.svh"

module tb_asr_top;
	localparam logic [7:0] ON = (8'h01 << `ASR_CB_RX_CONT_EN) | (8'h01 << `ASR_CB_PORT_EN);
	localparam logic [7:0] IRQ = (8'h01 << `ASR_CB_RXIE) | (8'h01 << `ASR_CB_PERIPH_IE) |
		(8'h01 << `ASR_CB_GLOBAL_IE);
	localparam logic [7:0] NINE = 8'h01 << `ASR_CB_NINE;
	localparam logic [7:0] ADR = 8'h01 << `ASR_CB_ADDR_DET;
	localparam logic [7:0] SYN = 8'h01 << `ASR_CB_SYNC;
	localparam logic [3:0] ST = `ASR_OFF_STATUS;
	localparam logic [3:0] DT = `ASR_OFF_DATA;
	logic sys_clk, rst_b, rd, wr, wreq, irq, line;
	logic tick = 1'b0;
	logic [3:0] addr, be;
	logic [31:0] wd, rdata;
	int fail_count, cmp_count;
	int tcnt = 0;

	asr_tx_model tx (.clk_in(sys_clk), .tick_in(tick), .line_out(line));
	asr_top dut (
		.sys_clk_in(sys_clk),
		.rst_b_in(rst_b),
		.serial_in_pin_in(line),
		.baud_tick_in(tick),
		.avs_address_in(addr),
		.avs_read_in(rd),
		.avs_write_in(wr),
		.avs_writedata_in(wd),
		.avs_byteenable_in(be),
		.avs_readdata_out(rdata),
		.avs_waitrequest_out(wreq),
		.rx_irq_out(irq)
	);

	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// oversample tick every fourth clock
	always @(posedge sys_clk) begin
		tcnt <= (tcnt + 1) % 4;
		tick <= (tcnt == 3);
	end

	// expected status word
	function automatic logic [31:0] st(input logic p, input logic o, input logic f,
			input logic n);
		st = 32'h0;
		st[`ASR_SB_PEND] = p;
		st[`ASR_SB_OVERRUN] = o;
		st[`ASR_SB_FERR] = f;
		st[`ASR_SB_BIT8] = n;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one bus access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] b, output logic [31:0] q);
		int n;
		n = 0;
		addr <= a;
		wd <= d;
		be <= b;
		rd <= !w;
		wr <= w;
		@(posedge sys_clk);
		while (wreq !== 1'b0) begin
			n++;
			if (n > 100) begin
				fail_count++;
				print_verdict();
			end
			@(posedge sys_clk);
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr_ctrl(input logic [7:0] c);
		logic [31:0] q;
		bus(1'b1, `ASR_OFF_CTRL, {24'h0, c}, 4'hF, q);
	endtask

	task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'h0, q);
		chk(nm, e, q);
	endtask

	task automatic t_regs();
		logic [31:0] q;
		rd_chk("ctrl reset", `ASR_OFF_CTRL, 32'h0);
		rd_chk("status idle", ST, 32'h0);
		bus(1'b1, `ASR_OFF_CTRL, 32'hFF, 4'hE, q);
		rd_chk("ctrl no lane", `ASR_OFF_CTRL, 32'h0);
		bus(1'b1, ST, 32'hFF, 4'hF, q);
		rd_chk("status ro", ST, 32'h0);
		rd_chk("unmapped", 4'hC, 32'h0);
		tx.send(9'h0F0, 8, 1'b1);
		rd_chk("disabled", ST, 32'h0);
		wr_ctrl(ON | SYN);
		tx.send(9'h0F0, 8, 1'b1);
		rd_chk("sync mode", ST, 32'h0);
	endtask

	task automatic t_basic();
		wr_ctrl(ON | IRQ);
		tx.send(9'h0A5, 8, 1'b1);
		repeat (3) @(posedge sys_clk);
		chk("irq on", 32'h1, {31'h0, irq});
		wr_ctrl(ON);
		repeat (3) @(posedge sys_clk);
		chk("irq gated", 32'h0, {31'h0, irq});
		rd_chk("pending", ST, st(1, 0, 0, 0));
		rd_chk("data", DT, 32'hA5);
		rd_chk("popped", ST, st(0, 0, 0, 0));
		tx.glitch();
		rd_chk("glitch", ST, st(0, 0, 0, 0));
		tx.send(9'h03C, 8, 1'b0);
		rd_chk("framing", ST, st(1, 0, 1, 0));
		rd_chk("framed data", DT, 32'h3C);
		tx.send(9'h0C3, 8, 1'b1);
		rd_chk("framing clear", ST, st(1, 0, 0, 0));
		rd_chk("data two", DT, 32'hC3);
	endtask

	task automatic t_fifo();
		tx.send(9'h011, 8, 1'b1);
		tx.send(9'h022, 8, 1'b1);
		tx.send(9'h033, 8, 1'b1);
		rd_chk("overrun", ST, st(1, 1, 0, 0));
		rd_chk("oldest", DT, 32'h11);
		rd_chk("second", DT, 32'h22);
		tx.send(9'h044, 8, 1'b1);
		rd_chk("blocked", ST, st(0, 1, 0, 0));
		wr_ctrl(ON & ~(8'h01 << `ASR_CB_RX_CONT_EN));
		rd_chk("overrun clear", ST, st(0, 0, 0, 0));
		wr_ctrl(ON);
		tx.send(9'h055, 8, 1'b1);
		rd_chk("resumed", DT, 32'h55);
	endtask

	task automatic t_nine();
		wr_ctrl(ON | NINE);
		tx.send(9'h13C, 9, 1'b1);
		rd_chk("ninth bit", ST, st(1, 0, 0, 1));
		rd_chk("nine low", DT, 32'h3C);
		wr_ctrl(ON | NINE | ADR);
		tx.send(9'h055, 9, 1'b1);
		rd_chk("addr drop", ST, st(0, 0, 0, 0));
		tx.send(9'h1AA, 9, 1'b1);
		rd_chk("addr keep", DT, 32'hAA);
		wr_ctrl(ON | NINE);
		tx.send(9'h077, 9, 1'b1);
		rd_chk("after addr", ST, st(1, 0, 0, 0));
		rd_chk("after data", DT, 32'h77);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// reset, then the scenarios in turn
	initial begin
		rst_b = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wd = 32'h0;
		be = 4'h0;
		fail_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_basic();
		t_fifo();
		t_nine();
		print_verdict();
	end

	// watchdog well beyond the expected run time
	initial begin
		#400us;
		fail_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
